// [rtl/dtc_pkg.sv]
package dtc_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [9:0] IDX_CONTROL = 10'h088;
    localparam logic [9:0] IDX_MODE = 10'h089;
    localparam logic [9:0] IDX_ZERO_LOW = 10'h08A;
    localparam logic [9:0] IDX_ONE_LOW = 10'h08B;
    localparam logic [9:0] IDX_ZERO_HIGH = 10'h08C;
    localparam logic [9:0] IDX_ONE_HIGH = 10'h08D;
    localparam logic [9:0] IDX_CLOCK_SEL = 10'h08E;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // prescaler ratios
    localparam int DIV_FAST = 4;
    localparam int DIV_MID = 12;
    localparam int DIV_SLOW = 48;
    localparam int DIV_EXT = 8;
    // mode encodings
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT = 2'h3;
    localparam int LOW13_BITS = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // synchronised pin slots
    localparam int PIN_T0 = 0;
    localparam int PIN_T1 = 1;
    localparam int PIN_E0 = 2;
    localparam int PIN_E1 = 3;
    localparam int PIN_XCLK = 4;
    localparam int PIN_COUNT = 5;

    typedef struct packed {
        logic timerOneOverflowFlag;
        logic timerOneRun;
        logic timerZeroOverflowFlag;
        logic timerZeroRun;
        logic extIrqOneFlag;
        logic extIrqOneType;
        logic extIrqZeroFlag;
        logic extIrqZeroType;
    } dtc_control_t;

    typedef struct packed {
        logic gating;
        logic countSelect;
        logic [1:0] modeField;
    } dtc_tmode_t;

    typedef struct packed {
        dtc_tmode_t one;
        dtc_tmode_t zero;
    } dtc_mode_t;

    typedef struct packed {
        logic thirdTimerHighClockSel;
        logic thirdTimerLowClockSel;
        logic secondTimerHighClockSel;
        logic secondTimerLowClockSel;
        logic timerOneClockSel;
        logic timerZeroClockSel;
        logic [1:0] prescaleField;
    } dtc_clksel_t;

    typedef struct packed {
        logic ovf;
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;

    typedef enum logic [1:0] {WR_COLLECT = 2'h0, WR_RESP = 2'h1} dtc_wr_t;
    typedef enum logic [1:0] {RD_IDLE = 2'h0, RD_RESP = 2'h1} dtc_rd_t;
endpackage

// [rtl/dtc_timers.sv]
`timescale 1ns/1ps
// Overview of operation
// - timer one overflow sets its flag; vector clears
// - timer zero overflow sets its flag; vector clears
// - run bits enable timers, subject to gating
// - ext one flag: edge clears on vector
// - ext one level mode: flag follows level
// - ext zero flag behaves like ext one
// - type bit: 0 level, 1 edge
// - input polarity comes from outside configuration
// - timer one gate needs ext one active
// - timer zero gate needs ext zero active
// - timer one counts count pin falling edges
// - timer zero counts count pin falling edges
// - timer one modes: 13, 16, reload, off
// - timer zero modes: 13, 16, reload, split
// - timer one clock: prescaled or system
// - timer zero clock: prescaled or system
// - prescale: /12, /4, /48, external /8
// - external divide-by-eight is synchronised first
// - high-byte selects of timers two, three: split only
// - low-byte selects: external select or system clock
// - count bytes readable and writable separately
// - 13-bit mode wraps from all ones, flags
// - reload mode refills low byte from high
// - split high byte runs on timer one run
module dtc_timers
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic timerZeroCountPin,
    input wire logic timerOneCountPin,
    input wire logic extIrqZeroInput,
    input wire logic extIrqOneInput,
    input wire logic extClkPin,
    input wire logic extIrqZeroPolarity,
    input wire logic extIrqOnePolarity,
    input wire logic vecTimerZero,
    input wire logic vecTimerOne,
    input wire logic vecExtZero,
    input wire logic vecExtOne,
    input wire logic secondTimerExtSelect,
    input wire logic thirdTimerExtSelect,
    input wire logic secondTimerSplit,
    input wire logic thirdTimerSplit,
    output logic timerZeroOverflowFlag,
    output logic timerOneOverflowFlag,
    output logic extIrqZeroFlag,
    output logic extIrqOneFlag,
    output logic secondTimerHighTick,
    output logic secondTimerLowTick,
    output logic thirdTimerHighTick,
    output logic thirdTimerLowTick
);
    dtc_control_t ctrlReg;
    dtc_mode_t modeReg;
    dtc_clksel_t clkReg;
    logic [7:0] zLowReg, zHighReg, oLowReg, oHighReg;
    logic [PIN_COUNT-1:0] pinMetaReg, pinSyncReg, pinPrevReg;
    logic [5:0] preCntReg;
    logic [2:0] extCntReg;
    dtc_wr_t wrStateReg;
    dtc_rd_t rdStateReg;
    logic awHeldReg, wHeldReg;
    logic [11:0] awAddrReg;
    logic [7:0] wByteReg;
    logic wLaneReg;

    // 13/16-bit, reload and split stepping shared by both timers
    function automatic dtc_count_t dtcAdvance(input logic [1:0] m,
        input logic [7:0] hi, input logic [7:0] lo);
        dtc_count_t r;
        r.ovf = 1'b0;
        r.high = hi;
        r.low = lo;
        case (m)
            MODE_13:
            begin
                r.ovf = &{hi, lo[LOW13_BITS-1:0]};
                {r.high, r.low[LOW13_BITS-1:0]} =
                    {hi, lo[LOW13_BITS-1:0]} + 1'b1;
            end
            MODE_16:
            begin
                r.ovf = &{hi, lo};
                {r.high, r.low} = {hi, lo} + 1'b1;
            end
            MODE_RELOAD:
            begin
                r.ovf = &lo;
                r.low = (&lo) ? hi : lo + 8'h01;
            end
            default:
            begin
                r.ovf = &lo;
                r.low = lo + 8'h01;
            end
        endcase
        return r;
    endfunction

    // three flops per pin; only the second stage and later are read
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pinMetaReg <= '0;
            pinSyncReg <= '0;
            pinPrevReg <= '0;
        end
        else if (ce)
        begin
            pinMetaReg <= {extClkPin, extIrqOneInput, extIrqZeroInput,
                timerOneCountPin, timerZeroCountPin};
            pinSyncReg <= pinMetaReg;
            pinPrevReg <= pinSyncReg;
        end
    end

    logic t0Fall, t1Fall, extRise;
    logic e0Active, e1Active, e0WasActive, e1WasActive;
    assign t0Fall = pinPrevReg[PIN_T0] && !pinSyncReg[PIN_T0];
    assign t1Fall = pinPrevReg[PIN_T1] && !pinSyncReg[PIN_T1];
    assign extRise = !pinPrevReg[PIN_XCLK] && pinSyncReg[PIN_XCLK];
    // polarity 1 means the input is active high
    assign e0Active = pinSyncReg[PIN_E0] == extIrqZeroPolarity;
    assign e1Active = pinSyncReg[PIN_E1] == extIrqOnePolarity;
    assign e0WasActive = pinPrevReg[PIN_E0] == extIrqZeroPolarity;
    assign e1WasActive = pinPrevReg[PIN_E1] == extIrqOnePolarity;

    // one free-running count yields all three system-clock ratios
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            preCntReg <= '0;
        else if (ce)
            preCntReg <= (preCntReg == 6'(DIV_SLOW - 1)) ? '0
                : preCntReg + 6'h01;
    end

    // external clock counted only after synchronisation
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            extCntReg <= '0;
        else if (ce && extRise)
            extCntReg <= extCntReg + 3'h1;
    end

    logic tick4, tick12, tick48, tickExt, tickPre;
    assign tick4 = (preCntReg % 6'(DIV_FAST)) == 6'(DIV_FAST - 1);
    assign tick12 = (preCntReg % 6'(DIV_MID)) == 6'(DIV_MID - 1);
    assign tick48 = preCntReg == 6'(DIV_SLOW - 1);
    assign tickExt = extRise && (extCntReg == 3'(DIV_EXT - 1));

    always_comb
    begin
        case (clkReg.prescaleField)
            PRE_DIV12: tickPre = tick12;
            PRE_DIV4: tickPre = tick4;
            PRE_DIV48: tickPre = tick48;
            default: tickPre = tickExt;
        endcase
    end

    // run, gate and source selection
    logic zeroSplit, zeroGo, zeroHighGo, oneGo, tick0, tick1;
    assign zeroSplit = modeReg.zero.modeField == MODE_SPLIT;
    assign tick0 = modeReg.zero.countSelect ? t0Fall
        : (clkReg.timerZeroClockSel || tickPre);
    assign tick1 = (modeReg.one.countSelect && !zeroSplit) ? t1Fall
        : (clkReg.timerOneClockSel || tickPre);
    assign zeroGo = ctrlReg.timerZeroRun && tick0 &&
        (!modeReg.zero.gating || e0Active);
    // the split high byte keeps the timer-zero clock choice
    assign zeroHighGo = zeroSplit && ctrlReg.timerOneRun &&
        (clkReg.timerZeroClockSel || tickPre);
    // with timer zero split, timer one runs on its mode alone
    assign oneGo = tick1 && (modeReg.one.modeField != MODE_SPLIT) &&
        (zeroSplit || (ctrlReg.timerOneRun &&
        (!modeReg.one.gating || e1Active)));

    // register write strobe, taken once address and data are both held and byte lane zero was strobed
    logic wrDo;
    logic [9:0] wrIdx;
    assign wrDo = (wrStateReg == WR_COLLECT) && awHeldReg && wHeldReg &&
        wLaneReg;
    assign wrIdx = awAddrReg[11:2];

    dtc_count_t zStep, oStep;
    logic [7:0] zLowNext, zHighNext, oLowNext, oHighNext;
    logic t0OvfEvt, t1OvfEvt, t1SplitEvt;

    // next counts; a software write to a byte wins over its step
    always_comb
    begin
        zStep = dtcAdvance(modeReg.zero.modeField, zHighReg, zLowReg);
        oStep = dtcAdvance(modeReg.one.modeField, oHighReg, oLowReg);
        zLowNext = zLowReg;
        zHighNext = zHighReg;
        oLowNext = oLowReg;
        oHighNext = oHighReg;
        t0OvfEvt = 1'b0;
        t1OvfEvt = 1'b0;
        t1SplitEvt = 1'b0;
        if (zeroGo)
        begin
            zLowNext = zStep.low;
            t0OvfEvt = zStep.ovf;
            if (!zeroSplit)
                zHighNext = zStep.high;
        end
        if (zeroHighGo)
        begin
            zHighNext = zHighReg + 8'h01;
            t1SplitEvt = &zHighReg;
        end
        if (oneGo)
        begin
            oLowNext = oStep.low;
            oHighNext = oStep.high;
            t1OvfEvt = oStep.ovf && !zeroSplit;
        end
        if (wrDo && wrIdx == IDX_ZERO_LOW)
            zLowNext = wByteReg;
        if (wrDo && wrIdx == IDX_ZERO_HIGH)
            zHighNext = wByteReg;
        if (wrDo && wrIdx == IDX_ONE_LOW)
            oLowNext = wByteReg;
        if (wrDo && wrIdx == IDX_ONE_HIGH)
            oHighNext = wByteReg;
    end

    // count bytes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            zLowReg <= RESET_BYTE;
            zHighReg <= RESET_BYTE;
            oLowReg <= RESET_BYTE;
            oHighReg <= RESET_BYTE;
        end
        else if (ce)
        begin
            zLowReg <= zLowNext;
            zHighReg <= zHighNext;
            oLowReg <= oLowNext;
            oHighReg <= oHighNext;
        end
    end

    // mode and clock select bytes
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            modeReg <= dtc_mode_t'(RESET_BYTE);
            clkReg <= dtc_clksel_t'(RESET_BYTE);
        end
        else if (ce && wrDo)
        begin
            if (wrIdx == IDX_MODE)
                modeReg <= dtc_mode_t'(wByteReg);
            if (wrIdx == IDX_CLOCK_SEL)
                clkReg <= dtc_clksel_t'(wByteReg);
        end
    end

    // control flags: a hardware set always beats any clear
    dtc_control_t ctrlNext, wCtrl;
    assign wCtrl = dtc_control_t'(wByteReg);
    always_comb
    begin
        ctrlNext = ctrlReg;
        if (wrDo && wrIdx == IDX_CONTROL)
            ctrlNext = wCtrl;
        if (vecTimerOne)
            ctrlNext.timerOneOverflowFlag = 1'b0;
        if (t1OvfEvt || t1SplitEvt)
            ctrlNext.timerOneOverflowFlag = 1'b1;
        if (vecTimerZero)
            ctrlNext.timerZeroOverflowFlag = 1'b0;
        if (t0OvfEvt)
            ctrlNext.timerZeroOverflowFlag = 1'b1;
        // edge mode: vector clears; level mode: flag tracks the active level
        if (vecExtOne && ctrlReg.extIrqOneType)
            ctrlNext.extIrqOneFlag = 1'b0;
        if (ctrlReg.extIrqOneType && e1Active && !e1WasActive)
            ctrlNext.extIrqOneFlag = 1'b1;
        if (!ctrlReg.extIrqOneType)
            ctrlNext.extIrqOneFlag = e1Active;
        if (vecExtZero && ctrlReg.extIrqZeroType)
            ctrlNext.extIrqZeroFlag = 1'b0;
        if (ctrlReg.extIrqZeroType && e0Active && !e0WasActive)
            ctrlNext.extIrqZeroFlag = 1'b1;
        if (!ctrlReg.extIrqZeroType)
            ctrlNext.extIrqZeroFlag = e0Active;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ctrlReg <= dtc_control_t'(RESET_BYTE);
        else if (ce)
            ctrlReg <= ctrlNext;
    end

    assign timerOneOverflowFlag = ctrlReg.timerOneOverflowFlag;
    assign timerZeroOverflowFlag = ctrlReg.timerZeroOverflowFlag;
    assign extIrqOneFlag = ctrlReg.extIrqOneFlag;
    assign extIrqZeroFlag = ctrlReg.extIrqZeroFlag;

    // clock enables for timers two and three, registered once
    logic tick2Ext, tick3Ext;
    assign tick2Ext = secondTimerExtSelect ? tickExt : tick12;
    assign tick3Ext = thirdTimerExtSelect ? tickExt : tick12;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            secondTimerHighTick <= 1'b0;
            secondTimerLowTick <= 1'b0;
            thirdTimerHighTick <= 1'b0;
            thirdTimerLowTick <= 1'b0;
        end
        else if (ce)
        begin
            secondTimerHighTick <= secondTimerSplit &&
                (clkReg.secondTimerHighClockSel || tick2Ext);
            thirdTimerHighTick <= thirdTimerSplit &&
                (clkReg.thirdTimerHighClockSel || tick3Ext);
            secondTimerLowTick <= clkReg.secondTimerLowClockSel ||
                tick2Ext;
            thirdTimerLowTick <= clkReg.thirdTimerLowClockSel || tick3Ext;
        end
    end

    // write channel: address and data held in either order
    logic wrHit;
    assign wrHit = wrIdx inside {IDX_CONTROL, IDX_MODE, IDX_ZERO_LOW,
        IDX_ONE_LOW, IDX_ZERO_HIGH, IDX_ONE_HIGH, IDX_CLOCK_SEL};
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrStateReg <= WR_COLLECT;
            awHeldReg <= 1'b0;
            wHeldReg <= 1'b0;
            awAddrReg <= '0;
            wByteReg <= RESET_BYTE;
            wLaneReg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            case (wrStateReg)
                WR_COLLECT:
                begin
                    if (s_axi_awvalid && s_axi_awready)
                    begin
                        awHeldReg <= 1'b1;
                        awAddrReg <= s_axi_awaddr;
                        s_axi_awready <= 1'b0;
                    end
                    else if (!awHeldReg)
                        s_axi_awready <= 1'b1;
                    if (s_axi_wvalid && s_axi_wready)
                    begin
                        wHeldReg <= 1'b1;
                        wByteReg <= s_axi_wdata[7:0];
                        wLaneReg <= s_axi_wstrb[0];
                        s_axi_wready <= 1'b0;
                    end
                    else if (!wHeldReg)
                        s_axi_wready <= 1'b1;
                    if (awHeldReg && wHeldReg)
                    begin
                        awHeldReg <= 1'b0;
                        wHeldReg <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_DECERR;
                        wrStateReg <= WR_RESP;
                    end
                end
                WR_RESP:
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wrStateReg <= WR_COLLECT;
                    end
                default: wrStateReg <= WR_COLLECT;
            endcase
        end
    end

    // read mux; unmapped addresses read zero with a decode error
    logic [7:0] rdByte;
    logic rdHit;
    always_comb
    begin
        rdHit = 1'b1;
        case (s_axi_araddr[11:2])
            IDX_CONTROL: rdByte = ctrlReg;
            IDX_MODE: rdByte = modeReg;
            IDX_ZERO_LOW: rdByte = zLowReg;
            IDX_ONE_LOW: rdByte = oLowReg;
            IDX_ZERO_HIGH: rdByte = zHighReg;
            IDX_ONE_HIGH: rdByte = oHighReg;
            IDX_CLOCK_SEL: rdByte = clkReg;
            default:
            begin
                rdByte = RESET_BYTE;
                rdHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdStateReg <= RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            case (rdStateReg)
                RD_IDLE:
                    if (s_axi_arvalid && s_axi_arready)
                    begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= {24'h000000, rdByte};
                        s_axi_rresp <= rdHit ? RESP_OKAY : RESP_DECERR;
                        rdStateReg <= RD_RESP;
                    end
                    else
                        s_axi_arready <= 1'b1;
                RD_RESP:
                    if (s_axi_rready)
                    begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rdStateReg <= RD_IDLE;
                    end
                default: rdStateReg <= RD_IDLE;
            endcase
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_zero_ovf_flag: assert property (ce && t0OvfEvt |=>
        ctrlReg.timerZeroOverflowFlag) else $error("t0 flag not set");
    a_one_ovf_flag: assert property (ce && (t1OvfEvt || t1SplitEvt) |=>
        ctrlReg.timerOneOverflowFlag) else $error("t1 flag not set");
    a_run_off_hold: assert property (ce && !ctrlReg.timerZeroRun &&
        !wrDo && !zeroHighGo |=> $stable({zHighReg, zLowReg}))
        else $error("stopped timer zero moved");
    a_gate_blocks: assert property (ce && modeReg.zero.gating &&
        !e0Active && !wrDo && !zeroSplit |=> $stable({zHighReg, zLowReg}))
        else $error("gated timer zero moved");
    a_level_one: assert property (ce && !ctrlReg.extIrqOneType |=>
        ctrlReg.extIrqOneFlag == $past(e1Active))
        else $error("level flag one not following input");
    a_level_zero: assert property (ce && !ctrlReg.extIrqZeroType |=>
        ctrlReg.extIrqZeroFlag == $past(e0Active))
        else $error("level flag zero not following input");
    a_reload_fill: assert property (ce && zeroGo && !wrDo &&
        modeReg.zero.modeField == MODE_RELOAD && &zLowReg |=>
        zLowReg == $past(zHighReg) && $stable(zHighReg))
        else $error("reload mode did not refill");
    a_wrap_13: assert property (ce && zeroGo && !wrDo &&
        modeReg.zero.modeField == MODE_13 &&
        &{zHighReg, zLowReg[LOW13_BITS-1:0]} |=> zHighReg == RESET_BYTE &&
        zLowReg[LOW13_BITS-1:0] == '0 && ctrlReg.timerZeroOverflowFlag)
        else $error("13-bit wrap wrong");
    a_count_fall: assert property (ce && modeReg.zero.countSelect &&
        ctrlReg.timerZeroRun && !modeReg.zero.gating && t0Fall && !wrDo &&
        modeReg.zero.modeField == MODE_16 |=>
        {zHighReg, zLowReg} == $past({zHighReg, zLowReg}) + 16'h0001)
        else $error("falling edge not counted");
    a_ext_sync: assert property (ce && tickExt |-> $past(ce) &&
        !pinPrevReg[PIN_XCLK]) else $error("external tick unsynchronised");

    c_zero_ovf: cover property (ce && t0OvfEvt);
    c_split_high: cover property (ce && t1SplitEvt);
    c_edge_irq: cover property (ce && ctrlReg.extIrqZeroType &&
        e0Active && !e0WasActive);
    c_write_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule // dtc_timers

// [tb/dtc_pin_model.sv]
`timescale 1ns/1ps
// external count source and interrupt line, idle count level high
module dtc_pin_model (
    input wire logic clk,
    output logic cntPin,
    output logic irqPin
);
    initial cntPin = 1'b1;
    initial irqPin = 1'b0;
    // low level held three cycles, high level four between pulses, above the two-cycle minimum
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge clk) cntPin <= 1'b0;
            repeat (3) @(posedge clk);
            cntPin <= 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic irq(input logic v);
        @(posedge clk) irqPin <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule // dtc_pin_model

// [tb/dual_timer_control_clock_select_tb.sv]
`timescale 1ns/1ps
module dual_timer_control_clock_select_tb;
    import dtc_pkg::*;
    logic clk = 0, sys_rst = 1, av = 0, wv = 0, bb = 0, arv = 0, rr = 0;
    logic [11:0] aa = 12'h0, ra = 12'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [1:0] rsp;
    logic [3:0] vec = 4'h0, aux = 4'h0;
    logic [3:0] ws = 4'hF, tk;
    logic [1:0] pol = 2'h3;
    logic ce = 1'b1, xc = 1'b0;
    logic awr, wr_, bv, arr, rv, cp, ip, f0, f1, e0, e1;
    logic [1:0] br, rrs;
    logic [31:0] rd_;
    int n_errors = 0, checks_done = 0, cyc = 0;
    initial forever #2.5 clk = ~clk;
    // free-running external oscillator, one system cycle per level
    always @(posedge clk) xc <= ~xc;
    dtc_pin_model P (.clk(clk), .cntPin(cp), .irqPin(ip));
    dtc_timers DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bb), .s_axi_araddr(ra), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rrs),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .timerZeroCountPin(cp),
        .timerOneCountPin(cp), .extIrqZeroInput(ip), .extIrqOneInput(ip),
        .extClkPin(xc), .extIrqZeroPolarity(pol[0]),
        .extIrqOnePolarity(pol[1]), .vecTimerZero(vec[0]),
        .vecTimerOne(vec[1]), .vecExtZero(vec[2]), .vecExtOne(vec[3]),
        .secondTimerExtSelect(aux[0]), .thirdTimerExtSelect(aux[1]),
        .secondTimerSplit(aux[2]), .thirdTimerSplit(aux[3]),
        .timerZeroOverflowFlag(f0), .timerOneOverflowFlag(f1),
        .extIrqZeroFlag(e0), .extIrqOneFlag(e1),
        .secondTimerHighTick(tk[1]), .secondTimerLowTick(tk[0]),
        .thirdTimerHighTick(tk[3]), .thirdTimerLowTick(tk[2]));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        @(posedge clk);
        aa <= {i, 2'b00};
        wd <= {24'h0, d};
        {av, wv, bb} <= 3'b111;
        do
        begin
            @(posedge clk);
            if (awr) av <= 1'b0;
            if (wr_) wv <= 1'b0;
            if (bv && bb)
            begin
                bb <= 1'b0;
                rsp = br;
            end
        end while (av | wv | bb);
    endtask
    task automatic rd(input logic [9:0] i);
        @(posedge clk);
        ra <= {i, 2'b00};
        {arv, rr} <= 2'b11;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv && rr)
            begin
                rr <= 1'b0;
                rdat = rd_;
                rsp = rrs;
            end
        end while (arv | rr);
    endtask
    task automatic pv(input int b);
        @(posedge clk) vec[b] <= 1'b1;
        @(posedge clk) vec[b] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // enable pulses counted over a window of 48 cycles, any phase
    task automatic ticks(input int k, input int e);
        int n;
        n = 0;
        repeat (2) @(posedge clk);
        repeat (48)
        begin
            @(posedge clk);
            n += tk[k];
        end
        chk(8'(n), 8'(e));
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // cycle ceiling well above the expected run of under a thousand
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            n_errors++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(IDX_CLOCK_SEL);
        chk(rdat[7:0], RESET_BYTE);
        rd(10'h090);
        chk({6'h0, rsp}, {6'h0, RESP_DECERR});
        wr(IDX_ZERO_HIGH, 8'hF0);
        rd(IDX_ZERO_HIGH);
        chk(rdat[7:0], 8'hF0);
        // lane zero off: answered, but the byte keeps its value
        ws <= 4'hE;
        wr(IDX_ZERO_HIGH, 8'h55);
        chk({6'h0, rsp}, {6'h0, RESP_OKAY});
        ws <= 4'hF;
        // reload mode on the system clock overflows within a few cycles
        wr(IDX_ZERO_LOW, 8'hFE);
        wr(IDX_CLOCK_SEL, 8'h04);
        wr(IDX_MODE, {6'h0, MODE_RELOAD});
        wr(IDX_CONTROL, 8'h10);
        repeat (8) @(posedge clk);
        chk({7'h0, f0}, 8'h01);
        wr(IDX_CONTROL, 8'h20);
        rd(IDX_ZERO_HIGH);
        chk(rdat[7:0], 8'hF0);
        pv(0);
        chk({7'h0, f0}, 8'h00);
        // count mode, then gated while the interrupt line is inactive
        wr(IDX_MODE, 8'h05);
        wr(IDX_ZERO_LOW, 8'h00);
        wr(IDX_CONTROL, 8'h10);
        P.pulse(3);
        rd(IDX_ZERO_LOW);
        chk(rdat[7:0], 8'h03);
        // a pulse while the clock enable is low is never seen
        ce <= 1'b0;
        P.pulse(1);
        ce <= 1'b1;
        wr(IDX_MODE, 8'h0D);
        P.pulse(2);
        rd(IDX_ZERO_LOW);
        chk(rdat[7:0], 8'h03);
        // active-low polarity: the idle line opens the gate
        pol <= 2'h0;
        P.pulse(1);
        rd(IDX_ZERO_LOW);
        chk(rdat[7:0], 8'h04);
        pol <= 2'h3;
        // edge type: flag stays after the line drops, vector clears it
        wr(IDX_CONTROL, 8'h01);
        P.irq(1'b1);
        P.irq(1'b0);
        chk({7'h0, e0}, 8'h01);
        pv(2);
        chk({7'h0, e0}, 8'h00);
        // level type: flag follows the active level
        wr(IDX_CONTROL, 8'h00);
        P.irq(1'b1);
        chk({7'h0, e1}, 8'h01);
        P.irq(1'b0);
        chk({7'h0, e1}, 8'h00);
        // split mode: the high byte runs on timer one's run bit
        wr(IDX_ZERO_HIGH, 8'hFE);
        wr(IDX_MODE, {6'h0, MODE_SPLIT});
        wr(IDX_CONTROL, 8'h40);
        repeat (4) @(posedge clk);
        chk({7'h0, f1}, 8'h01);
        wr(IDX_CONTROL, 8'h80);
        pv(1);
        chk({7'h0, f1}, 8'h00);
        // timer two and three enables
        ticks(0, 4);
        ticks(1, 0);
        aux <= 4'hE;
        ticks(2, 3);
        ticks(1, 4);
        wr(IDX_CLOCK_SEL, 8'h84);
        ticks(3, 48);
        print_verdict;
    end
endmodule // dual_timer_control_clock_select_tb
